// ==== logic/adclvt_top.sv ====
`timescale 1ns/1ps
`include "adclvt_defines.svh"
module adclvt_top
  import adclvt_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        hwTrigger,
  input  wire logic        scanLater,
  output logic             convActive,
  output logic             convDone,
  output logic             irq
);

  logic [31:0]   ctrl_q;
  logic [2:0]    intSt_q;
  logic [2:0]    intEn_q;
  logic          ack_q;
  logic [31:0]   dat_q;
  adclvt_state_t state_q;
  logic [7:0]    phase_q;
  logic [4:0]    pre_q;
  logic          tick;
  logic          firstDone_q;
  logic [7:0]    halt_q;
  logic          done_q;
  logic          startBit;
  logic          cmpEn;
  logic          lowPwr;
  logic          seqMode;
  logic          hwMode;
  logic [2:0]    divSel;
  logic [1:0]    vmodeSel;
  logic          settingOk;
  logic [7:0]    waitLen;
  logic [7:0]    convLen;
  logic [7:0]    dlyLen;
  logic          busReq;
  logic          wrCtrl;
  logic          wrClr;
  logic          wrEn;
  logic          fieldChange;
  logic          skipWait;
  logic          evDone;
  logic          evBad;
  logic          evLate;
  logic [31:0]   ctrlMerged;

  assign ctrlMerged = merge(ctrl_q, dat_i, sel_i);
  assign startBit = ctrl_q[`ADCLVT_CTRL_START];
  assign cmpEn    = ctrl_q[`ADCLVT_CTRL_CMPEN];
  assign lowPwr   = ctrl_q[`ADCLVT_CTRL_LPSEL];
  assign seqMode  = ctrl_q[`ADCLVT_CTRL_SEQ];
  assign hwMode   = ctrl_q[`ADCLVT_CTRL_HWTRG];
  assign divSel   = ctrl_q[`ADCLVT_CTRL_DIV +: 3];
  assign vmodeSel = ctrl_q[`ADCLVT_CTRL_VMODE +: 2];

  // merge bytes by lane
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // the four legal settings only; anything else halts and flags
  always_comb begin
    settingOk = 1'b1;
    waitLen   = `ADCLVT_WAIT_SHORT;
    convLen   = `ADCLVT_CONV_SLOW;
    dlyLen    = `ADCLVT_IRQ_DLY;
    if (lowPwr || vmodeSel != `ADCLVT_VMODE_LOW) begin
      settingOk = 1'b0;
    end
    unique case (divSel)
      `ADCLVT_DIV_32, `ADCLVT_DIV_16: convLen = `ADCLVT_CONV_SLOW;
      `ADCLVT_DIV_2:                   convLen = `ADCLVT_CONV_FAST;
      `ADCLVT_DIV_1: begin
        waitLen = `ADCLVT_WAIT_LONG;
        convLen = `ADCLVT_CONV_FAST;
      end
      default: settingOk = 1'b0;
    endcase
    if (seqMode) begin
      dlyLen = `ADCLVT_IRQ_DLY - `ADCLVT_SEQ_SAVE;
    end
  end

  // conversion-clock enable pulse
  always_ff @(posedge clock) begin
    if (!nrst || state_q == ADCLVT_IDLE) begin
      pre_q <= 5'h00;
    end else if (tick) begin
      pre_q <= 5'h00;
    end else begin
      pre_q <= pre_q + 5'h01;
    end
  end

  always_comb begin
    unique case (divSel)
      `ADCLVT_DIV_32: tick = (pre_q == 5'h1f);
      `ADCLVT_DIV_16: tick = (pre_q == 5'h0f);
      `ADCLVT_DIV_2:  tick = (pre_q == 5'h01);
      default:        tick = 1'b1;
    endcase
  end

  assign busReq      = cyc_i && stb_i && !ack_q;
  assign wrCtrl      = busReq && we_i && adr_i == `ADCLVT_CTRL_OFS;
  assign wrClr       = busReq && we_i && adr_i == `ADCLVT_INTST_OFS;
  assign wrEn        = busReq && we_i && adr_i == `ADCLVT_INTEN_OFS;
  assign fieldChange = wrCtrl && (merge(ctrl_q, dat_i, sel_i) >> `ADCLVT_CTRL_DIV) != (ctrl_q >> `ADCLVT_CTRL_DIV);
  // wait omitted only in hardware-trigger mode, for later sequential conversions or scan 1-3
  assign skipWait    = hwMode && ((seqMode && firstDone_q) || scanLater);
  assign evDone      = state_q == ADCLVT_DLY && tick && phase_q == dlyLen - 8'h01;
  assign evBad       = startBit && !settingOk;
  // change refused while running or within the halt guard
  assign evLate      = fieldChange && (startBit || cmpEn || halt_q != 8'h00);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q <= `ADCLVT_CTRL_RST;
    end else if (wrCtrl) begin
      if (evLate) begin
        ctrl_q[7:0] <= ctrlMerged[7:0] & 8'h1f;
      end else begin
        ctrl_q <= ctrlMerged & 32'h0000_371f;
      end
    end else if (evBad) begin
      ctrl_q[`ADCLVT_CTRL_START] <= 1'b0;
    end else if (evDone && !seqMode) begin
      ctrl_q[`ADCLVT_CTRL_START] <= 1'b0;
    end
  end

  // guard after halting: counts the settle time
  always_ff @(posedge clock) begin
    if (!nrst) begin
      halt_q <= 8'h00;
    end else if (startBit || cmpEn) begin
      halt_q <= 8'(`ADCLVT_HALT_CYC);
    end else if (halt_q != 8'h00) begin
      halt_q <= halt_q - 8'h01;
    end
  end

  // sequencer; conversion period counted apart from the wait
  always_ff @(posedge clock) begin
    if (!nrst || !startBit || !cmpEn || !settingOk) begin
      state_q     <= ADCLVT_IDLE;
      phase_q     <= 8'h00;
      firstDone_q <= 1'b0;
    end else begin
      unique case (state_q)
        ADCLVT_IDLE: begin
          if (!hwMode || hwTrigger) begin
            state_q <= skipWait ? ADCLVT_CONV : ADCLVT_WAIT;
            phase_q <= 8'h00;
          end
        end
        ADCLVT_WAIT: if (tick) begin
          if (phase_q == waitLen - 8'h01) begin
            state_q <= ADCLVT_CONV;
            phase_q <= 8'h00;
          end else begin
            phase_q <= phase_q + 8'h01;
          end
        end
        ADCLVT_CONV: if (tick) begin
          if (phase_q == convLen - 8'h01) begin
            state_q <= ADCLVT_DLY;
            phase_q <= 8'h00;
          end else begin
            phase_q <= phase_q + 8'h01;
          end
        end
        ADCLVT_DLY: if (tick) begin
          if (evDone) begin
            state_q     <= ADCLVT_IDLE;
            phase_q     <= 8'h00;
            firstDone_q <= 1'b1;
          end else begin
            phase_q <= phase_q + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= evDone;
    end
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      intSt_q <= 3'h0;
    end else begin
      intSt_q <= (intSt_q & ~(wrClr && sel_i[0] ? dat_i[2:0] : 3'h0)) | {evLate, evBad, evDone};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      intEn_q <= 3'h0;
    end else if (wrEn && sel_i[0]) begin
      intEn_q <= dat_i[2:0];
    end
  end

  // one-wait-state slave; unmapped reads give zero; read data held between accesses
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq;
      if (busReq) unique case (adr_i)
        `ADCLVT_CTRL_OFS:  dat_q <= ctrl_q;
        `ADCLVT_STAT_OFS:  dat_q <= {22'h0, phase_q, state_q};
        `ADCLVT_INTEN_OFS: dat_q <= {29'h0, intEn_q};
        `ADCLVT_INTST_OFS: dat_q <= {29'h0, intSt_q};
        default:           dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o      = ack_q;
  assign dat_o      = dat_q;
  assign convActive = state_q != ADCLVT_IDLE;
  assign convDone   = done_q;
  assign irq        = |(intSt_q & intEn_q);

endmodule : adclvt_top

// ==== logic/adclvt_defines.svh ====
// Operation
// - in low-voltage mode (low-power select clear, voltage mode 10) a conversion is stabilization wait, conversion period, interrupt delay, all in conversion-clock cycles.
// - divider 000 or 001 gives peripheral clock over 32 or 16, with a 4-cycle wait, 80-cycle conversion and 4-cycle interrupt delay.
// - divider 100 gives peripheral clock over 2, with a 4-cycle wait, 107-cycle conversion and 4-cycle interrupt delay.
// - divider 101 gives the peripheral clock itself, with a 6-cycle wait, 107-cycle conversion and 4-cycle interrupt delay.
// - start time and stabilization wait are skipped for later conversions in sequential mode and for scan 1 to 3 channels after a hardware trigger.
//   (the logic skips the wait only in hardware-trigger mode, so software-triggered sequential conversions keep it.)
// - the listed interrupt delay is for one-shot mode; sequential mode raises the interrupt three conversion cycles sooner.
// - the conversion count excludes the wait, and software keeps conversion clock and time within the permitted range.
`ifndef ADCLVT_DEFINES_SVH
`define ADCLVT_DEFINES_SVH
`define ADCLVT_CTRL_OFS    4'h0
`define ADCLVT_STAT_OFS    4'h4
`define ADCLVT_INTST_OFS   4'h8
`define ADCLVT_INTEN_OFS   4'hc
`define ADCLVT_CTRL_START  0
`define ADCLVT_CTRL_CMPEN  1
`define ADCLVT_CTRL_LPSEL  2
`define ADCLVT_CTRL_SEQ    3
`define ADCLVT_CTRL_HWTRG  4
`define ADCLVT_CTRL_DIV    8
`define ADCLVT_CTRL_VMODE  12
`define ADCLVT_CTRL_RST    32'h0000_0000
`define ADCLVT_VMODE_LOW   2'h2
`define ADCLVT_DIV_32      3'h0
`define ADCLVT_DIV_16      3'h1
`define ADCLVT_DIV_2       3'h4
`define ADCLVT_DIV_1       3'h5
`define ADCLVT_WAIT_SHORT  8'h04
`define ADCLVT_WAIT_LONG   8'h06
`define ADCLVT_CONV_SLOW   8'h50
`define ADCLVT_CONV_FAST   8'h6b
`define ADCLVT_IRQ_DLY     8'h04
`define ADCLVT_SEQ_SAVE    8'h03
`define ADCLVT_EV_DONE     0
`define ADCLVT_EV_BADSET   1
`define ADCLVT_EV_LATEWR   2
`define ADCLVT_HALT_NS     200
`define ADCLVT_CLK_MHZ     250
`define ADCLVT_HALT_CYC    ((`ADCLVT_HALT_NS * `ADCLVT_CLK_MHZ + 999) / 1000)
`endif

// ==== logic/adclvt_pkg.sv ====
package adclvt_pkg;
  typedef enum logic [1:0] {ADCLVT_IDLE, ADCLVT_WAIT, ADCLVT_CONV, ADCLVT_DLY} adclvt_state_t;
endpackage : adclvt_pkg

// ==== bench/adclvt_asserts.sv ====
`timescale 1ns/1ps
module adclvt_asserts (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        hwTrigger,
  input wire logic        scanLater,
  input wire logic        convActive,
  input wire logic        convDone,
  input wire logic        irq
);
  // active cycles since last done; aborted runs only inflate it, so a lower bound stays safe
  int unsigned runCnt_q;
  always_ff @(posedge clock) begin
    if (!nrst || convDone) runCnt_q <= 0;
    else if (convActive) runCnt_q <= runCnt_q + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_ack; ack_o ##1 !ack_o; endsequence
  a_ack_follows: assert property (s_req |=> s_ack) else $error("no single ack after request");
  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
  a_data_held: assert property (!(cyc_i && stb_i) |=> $stable(dat_o)) else $error("read data moved");
  a_done_single: assert property (convDone |=> !convDone) else $error("done wider than one cycle");
  a_done_from_run: assert property (convDone |-> $past(convActive) || $past(convActive, 2))
    else $error("done without conversion");
  a_run_lower: assert property (convDone |-> runCnt_q >= 81) else $error("conversion too short");
  a_run_upper: assert property (convDone |-> runCnt_q <= 3000) else $error("conversion too long");
  a_quiet_reset: assert property (disable iff (1'b0) !nrst |=> !ack_o && !convDone && !convActive && !irq)
    else $error("outputs active after reset");
endmodule : adclvt_asserts

// ==== bench/adc_low_voltage_conversion_timing_tb.sv ====
`timescale 1ns/1ps
`include "adclvt_defines.svh"
module adc_low_voltage_conversion_timing_tb;
  logic        clock = 0, nrst = 0, cyc = 0, stb = 0, we = 0, hwTrigger = 0, scanLater = 0;
  logic [3:0]  adr = 0, sel = 0;
  logic [31:0] dat = 0, datO, cur = 0, v;
  logic        ackO, convActive, convDone, irq;
  int          errorCnt = 0, totalChecks = 0, n, n1, n2;
  logic [2:0]  dv[3] = '{3'h0, 3'h1, 3'h4};
  int          dd[3] = '{32, 16, 2};
  int          tk[3] = '{88, 88, 115};
  adclvt_top i_dut (.clock(clock), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(datO), .ack_o(ackO), .hwTrigger(hwTrigger), .scanLater(scanLater),
    .convActive(convActive), .convDone(convDone), .irq(irq));
  initial forever #2 clock = ~clock;
  function logic [31:0] fs(input logic [2:0] d);
    return {18'h0, `ADCLVT_VMODE_LOW, 1'b0, d, 8'h00};
  endfunction : fs
  task chk(input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      errorCnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task conclude;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ackO !== 1'b1 && k < 100);
    if (ackO !== 1'b1) errorCnt++;
    r = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : acc
  // halt with unchanged fields first, then sit out the guard before a new setting
  task go(input logic [31:0] f);
    acc(1'b1, 4'h0, cur, v);
    repeat (60) @(posedge clock);
    acc(1'b1, 4'h0, f, v);
    cur = f;
  endtask : go
  // latency from the control write to done; the first run is checked against a window, later ones by differences between runs
  task meas(input logic [31:0] c, input logic h, input logic s, output int m);
    acc(1'b1, 4'h0, c, v);
    scanLater <= s;
    hwTrigger <= h;
    @(posedge clock);
    hwTrigger <= 1'b0;
    m = 0;
    do begin
      @(posedge clock);
      m++;
    end while (convDone !== 1'b1 && m < 4000);
    if (convDone !== 1'b1) errorCnt++;
  endtask : meas
  initial begin
    repeat (20000) @(posedge clock);
    errorCnt++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    acc(1'b1, 4'hc, 32'h1, v);
    acc(1'b1, 4'h4, 32'hff, v);
    acc(1'b0, 4'h4, 32'h0, v);
    chk(v[1:0], 2'h0);
    acc(1'b0, 4'h2, 32'h0, v);
    go(fs(3'h5));
    meas(cur | 32'h3, 1'b0, 1'b0, n1);
    chk(n1 inside {[116:119]}, 1);
    chk(irq, 1'b1);
    meas(cur | 32'h3, 1'b0, 1'b1, n);
    chk(n, n1);
    meas(cur | 32'hb, 1'b0, 1'b0, n);
    chk(n, n1 - 3);
    go(cur);
    meas(cur | 32'h13, 1'b1, 1'b0, n);
    meas(cur | 32'h13, 1'b1, 1'b1, n2);
    chk(n - n2, 6);
    for (int i = 0; i < 3; i++) begin
      go(fs(dv[i]));
      meas(cur | 32'h3, 1'b0, 1'b0, n);
      chk((n - n1 + 117 - tk[i] * dd[i]) inside {[1 - dd[i]:dd[i] - 1]}, 1);
    end
    acc(1'b1, 4'h0, (cur & 32'hfffff8ff) | 32'h2, v);
    acc(1'b0, 4'h0, 32'h0, v);
    chk(v[10:8], 3'h4);
    acc(1'b0, 4'h8, 32'h0, v);
    chk(v[2:0], 3'h5);
    acc(1'b1, 4'h8, 32'h7, v);
    chk(irq, 1'b0);
    acc(1'b1, 4'h0, cur, v);
    acc(1'b1, 4'h0, fs(3'h5), v);
    acc(1'b1, 4'hc, 32'h0, v);
    chk(irq, 1'b0);
    acc(1'b1, 4'hc, 32'h4, v);
    chk(irq, 1'b1);
    acc(1'b1, 4'h8, 32'h4, v);
    chk(irq, 1'b0);
    go(32'h0000_0500);
    acc(1'b1, 4'hc, 32'h2, v);
    acc(1'b1, 4'h0, cur | 32'h3, v);
    repeat (4) @(posedge clock);
    chk(irq, 1'b1);
    acc(1'b0, 4'h0, 32'h0, v);
    chk(v[0], 1'b0);
    conclude;
  end
endmodule : adc_low_voltage_conversion_timing_tb
bind adclvt_top adclvt_asserts u_chk (.clock, .nrst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .hwTrigger, .scanLater, .convActive, .convDone, .irq);
